/* pkg/selfe_pkg.sv */
// Shared constants, types and arithmetic helpers of the speech front end.
package selfe_pkg;
	localparam int SMP_W     = 13;
	localparam int DAT_W     = 16;
	localparam int ACC_W     = 40;
	localparam int ACF_LAGS  = 9;
	localparam int ORDER     = 8;
	localparam int FRAME_LEN = 160;
	localparam int FRAME_MS  = 20;
	localparam int FRAME_BITS = 260;
	localparam int HEAD_BITS = 148;
	localparam int SUB_BITS  = 56;
	localparam int PULSES    = 13;
	localparam int DIV_STEPS = 15;
	localparam logic [7:0] LAST_IDX = 8'h9f;
	localparam logic [8:0] LAST_BIT = 9'h103;
	localparam logic signed [16:0] ALPHA_Q15 = 17'sh07fdf;
	localparam logic signed [16:0] BETA_Q15  = 17'sh06e14;
	localparam logic signed [32:0] ROUND_Q15 = 33'sh000004000;
	// Forward map thresholds in Q15, offsets in Q13.
	localparam logic [17:0] R_KNEE1   = 18'h05666;
	localparam logic [17:0] R_KNEE2   = 18'h0799a;
	localparam logic [17:0] L_OFS1    = 18'h0159a;
	localparam logic [17:0] L_OFS2    = 18'h0cc00;
	// Inverse map thresholds in Q13, offsets in Q15.
	localparam logic [17:0] L_KNEE1   = 18'h0159a;
	localparam logic [17:0] L_KNEE2   = 18'h02733;
	localparam logic [17:0] L_LIMIT   = 18'h03400;
	localparam logic [17:0] R_OFS1    = 18'h02b33;
	localparam logic [17:0] R_OFS2    = 18'h06600;
	localparam logic [17:0] Q15_MAX   = 18'h07fff;
	localparam int CLK_HZ       = 50_000_000;
	localparam int DELAY_MAX_MS = 30;
	localparam int DELAY_MIN_MS = 20;
	localparam int DELAY_MAX_CYC = DELAY_MAX_MS * (CLK_HZ / 1000);

	typedef enum {
		ST_IDLE, ST_NORM, ST_TEST, ST_DIV, ST_EMIT, ST_UPD, ST_ZERO
	} selfe_state_t;

	function automatic logic signed [15:0] selfe_sat16(
		input logic signed [33:0] v);
		if (v > 34'sh000007fff)
			return 16'sh7fff;
		else if (v < -34'sh000008000)
			return 16'sh8000;
		else
			return v[15:0];
	endfunction : selfe_sat16

	function automatic logic signed [15:0] selfe_mult_r(
		input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [32:0] p;
		p = 33'(a) * 33'(b) + ROUND_Q15;
		return selfe_sat16(34'(p >>> 15));
	endfunction : selfe_mult_r

	function automatic logic [17:0] selfe_abs(input logic signed [15:0] v);
		logic signed [17:0] w;
		w = 18'(v);
		return (v < 0) ? 18'(-w) : 18'(w);
	endfunction : selfe_abs
endpackage : selfe_pkg

/* rtl/selfe_front_end.sv */
// Speech encoder front end: filters, framing, analysis, maps and packer.
//
// Overview of operation
// - Sub-frames three, four: lag, gain, grid, peak, 13 pulses, LSB first.
// - Encoder plus decoder delay should stay below 30 ms, 20 ms minimum.
// - Delay counts from a full 160-sample frame entering to output.
// - Offset removal: input minus last input plus 32735/32768 last output.
// - Pre-emphasis subtracts 28180/32768 times the last offset-free sample.
// - Samples form consecutive non-overlapping 160-sample frames of 20 ms.
// - One fresh order-eight analysis per frame gives eight reflections.
// - Nine autocorrelation sums, lags zero to eight, i from lag to 159.
// - Reflection coefficients one to eight come from the Schur recursion.
// - Reflection to log-area ratio by three signed linear segments.
// - Log-area ratio back to reflection by three signed linear segments.
// - Coded parameters leave as one fixed 260-bit sequence per frame.
`timescale 1ns/10ps
module selfe_front_end
	import selfe_pkg::*;
#(
	parameter int DELAY_LIMIT_CYC = DELAY_MAX_CYC
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_i,
	input  wire logic signed [SMP_W-1:0]  sample_i,
	input  wire logic                     sample_valid_i,
	input  wire logic signed [15:0]       log_area_ratio_in_i,
	input  wire logic                     log_area_ratio_in_valid_i,
	input  wire logic [HEAD_BITS-1:0]     head_bits_i,
	input  wire logic [6:0]               pitch_lag_sub3_i,
	input  wire logic [1:0]               pitch_gain_sub3_i,
	input  wire logic [1:0]               pulse_grid_sub3_i,
	input  wire logic [5:0]               block_peak_code_sub3_i,
	input  wire logic [3*PULSES-1:0]      pulse_codes_sub3_i,
	input  wire logic [6:0]               pitch_lag_sub4_i,
	input  wire logic [1:0]               pitch_gain_sub4_i,
	input  wire logic [1:0]               pulse_grid_sub4_i,
	input  wire logic [5:0]               block_peak_code_sub4_i,
	input  wire logic [3*PULSES-1:0]      pulse_codes_sub4_i,
	input  wire logic                     pack_start_i,
	output logic signed [DAT_W-1:0]       emph_sample_o,
	output logic                          emph_valid_o,
	output logic [ACF_LAGS-1:0][ACC_W-1:0] autocorr_values_o,
	output logic                          autocorr_valid_o,
	output logic signed [15:0]            refl_coef_o,
	output logic signed [15:0]            log_area_ratio_o,
	output logic [3:0]                    coef_index_o,
	output logic                          coef_valid_o,
	output logic signed [15:0]            refl_inv_o,
	output logic                          refl_inv_valid_o,
	output logic                          pack_busy_o,
	output logic                          frame_bit_o,
	output logic                          frame_bit_valid_o,
	output logic                          frame_bit_last_o
);
	logic signed [SMP_W-1:0]  prev_in_reg;
	logic signed [DAT_W-1:0]  offset_free_signal;
	logic signed [DAT_W-1:0]  of_next;
	logic signed [DAT_W-1:0]  emph_next;
	logic [7:0]               idx_reg;
	logic signed [DAT_W-1:0]  hist_reg [1:ORDER];
	logic signed [ACC_W-1:0]  acc_reg [0:ORDER];
	logic signed [ACC_W-1:0]  acc_next [0:ORDER];
	selfe_state_t             state_reg;
	logic signed [15:0]       p_reg [0:ORDER];
	logic signed [15:0]       k_reg [1:ORDER];
	logic [3:0]               n_reg;
	logic [3:0]               m_reg;
	logic [3:0]               step_reg;
	logic [17:0]              num_reg;
	logic [17:0]              den_reg;
	logic [14:0]              quo_reg;
	logic signed [15:0]       r_reg;
	logic signed [15:0]       r_next;
	logic [5:0]               lz;
	logic [FRAME_BITS-1:0]    frame_sreg;
	logic [8:0]               bit_cnt_reg;

	function automatic logic signed [15:0] to_lar(input logic signed [15:0] r);
		logic [17:0] a;
		logic [17:0] mag;
		a = selfe_abs(r);
		if (a < R_KNEE1)
			mag = a >> 2;
		else if (a < R_KNEE2)
			mag = (a >> 1) - L_OFS1;
		else
			mag = (a << 1) - L_OFS2;
		return (r < 0) ? 16'(-$signed(mag)) : mag[15:0];
	endfunction : to_lar

	function automatic logic signed [15:0] to_refl(input logic signed [15:0] l);
		logic [17:0] a;
		logic [17:0] mag;
		a = selfe_abs(l);
		if (a < L_KNEE1)
			mag = a << 2;
		else if (a < L_KNEE2)
			mag = (a << 1) + R_OFS1;
		else
			mag = (((a > L_LIMIT) ? L_LIMIT : a) >> 1) + R_OFS2;
		if (mag > Q15_MAX)
			mag = Q15_MAX;
		return (l < 0) ? 16'(-$signed(mag)) : mag[15:0];
	endfunction : to_refl

	always_comb begin
		logic signed [33:0] t;
		t = 34'(sample_i) - 34'(prev_in_reg)
			+ ((34'(offset_free_signal) * 34'(ALPHA_Q15)) >>> 15);
		of_next = selfe_sat16(t);
		t = 34'(of_next)
			- ((34'(offset_free_signal) * 34'(BETA_Q15)) >>> 15);
		emph_next = selfe_sat16(t);
	end

	// Filter history starts from silence so the first frame is clean.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_in_reg        <= '0;
			offset_free_signal <= '0;
			emph_sample_o      <= '0;
			emph_valid_o       <= 1'b0;
		end else begin
			emph_valid_o <= sample_valid_i;
			if (sample_valid_i) begin
				prev_in_reg        <= sample_i;
				offset_free_signal <= of_next;
				emph_sample_o      <= emph_next;
			end
		end
	end

	// Lags are accumulated as samples arrive, so no frame store is needed.
	genvar g;
	generate
		for (g = 0; g <= ORDER; g++) begin : g_acf
			logic signed [DAT_W-1:0] lagged;
			if (g == 0) begin : g_self
				assign lagged = emph_sample_o;
			end else begin : g_hist
				assign lagged = (idx_reg >= 8'(g)) ? hist_reg[g] : '0;
			end
			assign acc_next[g] = ((idx_reg == 8'h00) ? '0 : acc_reg[g])
				+ ACC_W'(32'(emph_sample_o) * 32'(lagged));
		end
	endgenerate

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idx_reg           <= '0;
			autocorr_valid_o  <= 1'b0;
			autocorr_values_o <= '0;
			for (int i = 0; i <= ORDER; i++)
				acc_reg[i] <= '0;
			for (int i = 1; i <= ORDER; i++)
				hist_reg[i] <= '0;
		end else begin
			autocorr_valid_o <= 1'b0;
			if (emph_valid_o) begin
				for (int i = 0; i <= ORDER; i++)
					acc_reg[i] <= acc_next[i];
				hist_reg[1] <= emph_sample_o;
				for (int i = 2; i <= ORDER; i++)
					hist_reg[i] <= hist_reg[i-1];
				if (idx_reg == LAST_IDX) begin
					idx_reg          <= '0;
					autocorr_valid_o <= 1'b1;
					for (int i = 0; i <= ORDER; i++)
						autocorr_values_o[i] <= acc_next[i];
				end else begin
					idx_reg <= idx_reg + 8'h01;
				end
			end
		end
	end

	always_comb begin
		lz = '0;
		for (int b = 0; b < ACC_W - 1; b++)
			if (autocorr_values_o[0][b])
				lz = 6'(ACC_W - 2 - b);
	end

	assign r_next = (p_reg[1] > 0) ? -$signed({1'b0, quo_reg})
		: $signed({1'b0, quo_reg});

	// The recursion takes under two hundred cycles, far inside one frame time.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			n_reg <= '0;
			m_reg <= '0;
			step_reg <= '0;
			num_reg <= '0;
			den_reg <= '0;
			quo_reg <= '0;
			r_reg <= '0;
			coef_valid_o <= 1'b0;
			coef_index_o <= '0;
			refl_coef_o <= '0;
			log_area_ratio_o <= '0;
			for (int i = 0; i <= ORDER; i++)
				p_reg[i] <= '0;
			for (int i = 1; i <= ORDER; i++)
				k_reg[i] <= '0;
		end else begin
			coef_valid_o <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					n_reg <= 4'h1;
					if (autocorr_valid_o)
						state_reg <= ST_NORM;
				end
				ST_NORM: begin
					for (int i = 0; i <= ORDER; i++)
						p_reg[i] <= 16'((autocorr_values_o[i] <<< lz) >>> 24);
					for (int i = 1; i < ORDER; i++)
						k_reg[ORDER+1-i] <= 16'((autocorr_values_o[i] <<< lz)
							>>> 24);
					state_reg <= (autocorr_values_o[0] == '0) ? ST_ZERO : ST_TEST;
				end
				ST_TEST: begin
					num_reg  <= selfe_abs(p_reg[1]);
					den_reg  <= 18'(p_reg[0]);
					quo_reg  <= '0;
					step_reg <= '0;
					state_reg <= (18'(p_reg[0]) < selfe_abs(p_reg[1]))
						? ST_ZERO : ST_DIV;
				end
				ST_DIV: begin
					if ((num_reg << 1) >= den_reg) begin
						num_reg <= (num_reg << 1) - den_reg;
						quo_reg <= {quo_reg[13:0], 1'b1};
					end else begin
						num_reg <= num_reg << 1;
						quo_reg <= {quo_reg[13:0], 1'b0};
					end
					step_reg <= step_reg + 4'h1;
					if (step_reg == 4'(DIV_STEPS - 1))
						state_reg <= ST_EMIT;
				end
				ST_EMIT: begin
					r_reg <= r_next;
					refl_coef_o <= r_next;
					log_area_ratio_o <= to_lar(r_next);
					coef_index_o <= n_reg;
					coef_valid_o <= 1'b1;
					p_reg[0] <= selfe_sat16(34'(p_reg[0])
						+ 34'(selfe_mult_r(p_reg[1], r_next)));
					m_reg <= 4'h1;
					state_reg <= (n_reg == 4'(ORDER)) ? ST_IDLE : ST_UPD;
				end
				ST_UPD: begin
					p_reg[m_reg] <= selfe_sat16(34'(p_reg[m_reg+1])
						+ 34'(selfe_mult_r(k_reg[4'(ORDER+1)-m_reg], r_reg)));
					k_reg[4'(ORDER+1)-m_reg] <= selfe_sat16(
						34'(k_reg[4'(ORDER+1)-m_reg])
						+ 34'(selfe_mult_r(p_reg[m_reg+1], r_reg)));
					m_reg <= m_reg + 4'h1;
					if (m_reg == 4'(ORDER) - n_reg) begin
						n_reg <= n_reg + 4'h1;
						state_reg <= ST_TEST;
					end
				end
				ST_ZERO: begin
					refl_coef_o <= '0;
					log_area_ratio_o <= '0;
					coef_index_o <= n_reg;
					coef_valid_o <= 1'b1;
					n_reg <= n_reg + 4'h1;
					if (n_reg == 4'(ORDER))
						state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			refl_inv_o <= '0;
			refl_inv_valid_o <= 1'b0;
		end else begin
			refl_inv_valid_o <= log_area_ratio_in_valid_i;
			if (log_area_ratio_in_valid_i)
				refl_inv_o <= to_refl(log_area_ratio_in_i);
		end
	end

	// A start during a running frame is ignored so no frame is torn.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_sreg <= '0;
			bit_cnt_reg <= '0;
			pack_busy_o <= 1'b0;
			frame_bit_o <= 1'b0;
			frame_bit_valid_o <= 1'b0;
			frame_bit_last_o <= 1'b0;
		end else if (!pack_busy_o) begin
			frame_bit_valid_o <= 1'b0;
			frame_bit_last_o <= 1'b0;
			if (pack_start_i) begin
				frame_sreg <= {pulse_codes_sub4_i, block_peak_code_sub4_i,
					pulse_grid_sub4_i, pitch_gain_sub4_i, pitch_lag_sub4_i,
					pulse_codes_sub3_i, block_peak_code_sub3_i,
					pulse_grid_sub3_i, pitch_gain_sub3_i, pitch_lag_sub3_i,
					head_bits_i};
				bit_cnt_reg <= '0;
				pack_busy_o <= 1'b1;
			end
		end else begin
			frame_bit_o <= frame_sreg[0];
			frame_bit_valid_o <= 1'b1;
			frame_bit_last_o <= (bit_cnt_reg == LAST_BIT);
			frame_sreg <= frame_sreg >> 1;
			bit_cnt_reg <= bit_cnt_reg + 9'h001;
			if (bit_cnt_reg == LAST_BIT)
				pack_busy_o <= 1'b0;
		end
	end

	logic [21:0] lat_cnt_reg;
	logic [8:0]  sent_reg;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lat_cnt_reg <= '0;
			sent_reg <= '0;
		end else begin
			lat_cnt_reg <= autocorr_valid_o ? 22'h000001
				: (lat_cnt_reg != '0) ? lat_cnt_reg + 22'h000001 : '0;
			if (coef_valid_o && coef_index_o == 4'(ORDER))
				lat_cnt_reg <= '0;
			sent_reg <= frame_bit_last_o ? '0
				: frame_bit_valid_o ? sent_reg + 9'h001 : sent_reg;
		end
	end

	sequence s_div_done;
		state_reg == ST_DIV ##15 state_reg == ST_EMIT;
	endsequence
	property p_pack_lag3;
		@(posedge core_clk_i) disable iff (rst_i)
		pack_start_i && !pack_busy_o |=>
			frame_sreg[154:148] == $past(pitch_lag_sub3_i)
			&& frame_sreg[259:257] == $past(pulse_codes_sub4_i[38:36]);
	endproperty
	a_pack_lag3: assert property (p_pack_lag3)
		else $error("sub-frame fields misplaced");
	property p_delay;
		@(posedge core_clk_i) disable iff (rst_i)
		lat_cnt_reg < 22'(DELAY_LIMIT_CYC);
	endproperty
	a_delay: assert property (p_delay)
		else $error("analysis latency exceeds the delay budget");
	property p_frame_end;
		@(posedge core_clk_i) disable iff (rst_i)
		emph_valid_o && idx_reg == LAST_IDX |=>
			autocorr_valid_o && idx_reg == 8'h00;
	endproperty
	a_frame_end: assert property (p_frame_end)
		else $error("frame boundary not at sample 160");
	property p_offset;
		@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && sample_i == prev_in_reg && offset_free_signal == 0
			|=> offset_free_signal == 0 && emph_sample_o == 0;
	endproperty
	a_offset: assert property (p_offset)
		else $error("steady input did not give zero output");
	property p_preemph;
		@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && offset_free_signal == 0 |=>
			emph_sample_o == offset_free_signal;
	endproperty
	a_preemph: assert property (p_preemph)
		else $error("pre-emphasis wrong with silent history");
	property p_acf0;
		@(posedge core_clk_i) disable iff (rst_i)
		autocorr_valid_o |-> !autocorr_values_o[0][ACC_W-1];
	endproperty
	a_acf0: assert property (p_acf0)
		else $error("zero-lag energy negative");
	property p_eight_coefs;
		@(posedge core_clk_i) disable iff (rst_i)
		autocorr_valid_o |-> ##[1:400]
			(coef_valid_o && coef_index_o == 4'h8);
	endproperty
	a_eight_coefs: assert property (p_eight_coefs)
		else $error("eighth coefficient missing");
	property p_div;
		@(posedge core_clk_i) disable iff (rst_i)
		$rose(state_reg == ST_DIV) |-> s_div_done;
	endproperty
	a_div: assert property (p_div)
		else $error("division step count wrong");
	property p_lar_range;
		@(posedge core_clk_i) disable iff (rst_i)
		coef_valid_o |-> (selfe_abs(log_area_ratio_o) <= L_LIMIT)
			&& ((log_area_ratio_o < 0)
			== (refl_coef_o < 0 && log_area_ratio_o != 0));
	endproperty
	a_lar_range: assert property (p_lar_range)
		else $error("log-area ratio out of range or sign lost");
	property p_inv;
		@(posedge core_clk_i) disable iff (rst_i)
		log_area_ratio_in_valid_i |=> refl_inv_valid_o
			&& ((refl_inv_o < 0) == ($past(log_area_ratio_in_i) < 0));
	endproperty
	a_inv: assert property (p_inv)
		else $error("inverse map sign or strobe wrong");
	property p_bits;
		@(posedge core_clk_i) disable iff (rst_i)
		frame_bit_last_o |-> sent_reg == 9'h103;
	endproperty
	a_bits: assert property (p_bits)
		else $error("frame length not 260 bits");
endmodule : selfe_front_end

/* tb/selfe_front_end_bench.sv */
// Self-checking bench of the speech front end.
`timescale 1ns/10ps
module selfe_front_end_bench
	import selfe_pkg::*;
;
	logic                            core_clk_i = 1'b0;
	logic                            rst_i = 1'b1;
	logic                            send = 1'b0;
	logic signed [SMP_W-1:0]         val = '0;
	logic signed [SMP_W-1:0]         smp;
	logic                            smp_v;
	logic signed [15:0]              lar_in = '0;
	logic                            lar_v = 1'b0;
	logic                            start = 1'b0;
	logic [HEAD_BITS-1:0]            head = '0;
	logic [6:0]                      lag3 = '0, lag4 = '0;
	logic [1:0]                      gn3 = '0, gn4 = '0, gr3 = '0, gr4 = '0;
	logic [5:0]                      pk3 = '0, pk4 = '0;
	logic [3*PULSES-1:0]             pc3 = '0, pc4 = '0;
	logic signed [DAT_W-1:0]         emph;
	logic                            emph_v, acf_v, cv, rinv_v;
	logic [ACF_LAGS-1:0][ACC_W-1:0]  acf;
	logic signed [15:0]              rc, lar_o, rinv;
	logic [3:0]                      cidx;
	logic                            busy, fbit, fbv, flast;
	logic [31:0]                     rs = 32'h00000062;
	logic [FRAME_BITS-1:0]           pbits = '0;
	int                              miscompares = 0, n_compared = 0;
	int                              xp, sofp, idx, age, ncoef, nbit, r1_exp;
	longint                          a0 = 0;
	int                              frm[FRAME_LEN];
	int                              expq[$];
	logic signed [15:0]              invq[$];

	always #10 core_clk_i = ~core_clk_i;

	selfe_pcm_source src_u (.core_clk_i(core_clk_i), .send_i(send),
		.value_i(val), .sample_o(smp), .sample_valid_o(smp_v));

	selfe_front_end #(.DELAY_LIMIT_CYC(1000)) dut_u (
		.core_clk_i(core_clk_i), .rst_i(rst_i),
		.sample_i(smp), .sample_valid_i(smp_v),
		.log_area_ratio_in_i(lar_in), .log_area_ratio_in_valid_i(lar_v),
		.head_bits_i(head), .pitch_lag_sub3_i(lag3),
		.pitch_gain_sub3_i(gn3), .pulse_grid_sub3_i(gr3),
		.block_peak_code_sub3_i(pk3), .pulse_codes_sub3_i(pc3),
		.pitch_lag_sub4_i(lag4), .pitch_gain_sub4_i(gn4),
		.pulse_grid_sub4_i(gr4), .block_peak_code_sub4_i(pk4),
		.pulse_codes_sub4_i(pc4), .pack_start_i(start),
		.emph_sample_o(emph), .emph_valid_o(emph_v),
		.autocorr_values_o(acf), .autocorr_valid_o(acf_v),
		.refl_coef_o(rc), .log_area_ratio_o(lar_o),
		.coef_index_o(cidx), .coef_valid_o(cv),
		.refl_inv_o(rinv), .refl_inv_valid_o(rinv_v),
		.pack_busy_o(busy), .frame_bit_o(fbit),
		.frame_bit_valid_o(fbv), .frame_bit_last_o(flast));

	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd

	function automatic int sat(input int v);
		return (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
	endfunction : sat

	function automatic int fwd(input int r);
		int a;
		int e;
		a = (r < 0) ? -r : r;
		if (a < int'(R_KNEE1))
			e = a / 4;
		else if (a < int'(R_KNEE2))
			e = a / 2 - int'(L_OFS1);
		else
			e = 2 * a - int'(L_OFS2);
		return (r < 0) ? -e : e;
	endfunction : fwd

	function automatic int inv(input int l);
		int a;
		int e;
		a = (l < 0) ? -l : l;
		// Ratios beyond L_LIMIT are clamped, as the hand-over says.
		if (a > int'(L_LIMIT))
			a = int'(L_LIMIT);
		if (a < int'(L_KNEE1))
			e = a * 4;
		else if (a < int'(L_KNEE2))
			e = a * 2 + int'(R_OFS1);
		else
			e = a / 2 + int'(R_OFS2);
		if (e > 32767)
			e = 32767;
		return (l < 0) ? -e : e;
	endfunction : inv

	task automatic chk(input string nm, input logic [63:0] e, g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Map outputs are fixed-point approximations, so a small slack is allowed.
	task automatic near(input string nm, input int e,
		input logic signed [15:0] g, input int tol = 2);
		n_compared++;
		if ($isunknown(g) || e - g > tol || g - e > tol) begin
			miscompares++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask : near

	task automatic results();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	always @(negedge core_clk_i) begin
		if (!rst_i) begin
			if (acf_v === 1'b1) begin
				chk("acf_timing", 1, idx == FRAME_LEN && age == 0);
				for (int k = 0; k < ACF_LAGS; k++) begin
					longint s;
					s = 0;
					for (int i = k; i < FRAME_LEN; i++)
						s += longint'(frm[i]) * frm[i-k];
					chk("autocorr_values", s[ACC_W-1:0], acf[k]);
					if (k == 0)
						a0 = s;
					if (k == 1 && a0 > 0)
						r1_exp = int'(-s * 32768 / a0);
				end
				idx = 0;
				ncoef = 0;
			end
			if (emph_v === 1'b1) begin
				chk("emph_queue", 1, expq.size() > 0);
				if (expq.size() > 0 && idx < FRAME_LEN) begin
					frm[idx] = expq.pop_front();
					chk("emph_sample", frm[idx][15:0], {emph});
				end
				idx++;
				age = 0;
			end else
				age++;
			if (cv === 1'b1) begin
				ncoef++;
				chk("coef_index", ncoef, cidx);
				// Normalising to 16 bits costs a few steps of precision here.
				if (ncoef == 1 && a0 > 0)
					near("refl_coef_1", r1_exp, rc, 6);
				near("log_area_ratio", fwd(rc), lar_o);
			end
			if (rinv_v === 1'b1) begin
				chk("refl_inv_pending", 1, invq.size() > 0);
				if (invq.size() > 0)
					near("refl_inv", inv(invq.pop_front()), rinv);
			end
			if (fbv === 1'b1 && nbit < FRAME_BITS) begin
				chk("frame_bit", pbits[nbit], fbit);
				chk("frame_bit_last", nbit == FRAME_BITS - 1, flast);
				nbit++;
			end
		end
	end

	task automatic do_reset();
		@(negedge core_clk_i);
		rst_i <= 1'b1;
		@(negedge core_clk_i);
		chk("reset_outputs", 7'h00,
			{emph_v, acf_v, cv, busy, fbv, rinv_v, flast});
		@(negedge core_clk_i);
		@(negedge core_clk_i);
		xp = 0;
		sofp = 0;
		idx = 0;
		age = 0;
		ncoef = 0;
		expq.delete();
		rst_i <= 1'b0;
	endtask : do_reset

	task automatic put(input int n);
		logic signed [12:0] r;
		int sof;
		for (int i = 0; i < n; i++) begin
			r = 13'(rnd());
			if (i == 0)
				r = 13'h0000;
			if (i == 1)
				r = 13'h0fff;
			if (i == 2)
				r = 13'h1000;
			// The filters truncate their products toward minus infinity.
			sof = sat(r - xp + ((int'(ALPHA_Q15) * sofp) >>> 15));
			expq.push_back(sat(sof - ((int'(BETA_Q15) * sofp) >>> 15)));
			xp = r;
			sofp = sof;
			@(posedge core_clk_i);
			send = 1'b1;
			val = r;
			@(posedge core_clk_i);
			send = 1'b0;
		end
	endtask : put

	task automatic wait_coef();
		ncoef = 0;
		for (int c = 0; c < 400 && ncoef < ORDER; c++)
			@(negedge core_clk_i);
		chk("coef_count", ORDER, ncoef);
		if (ncoef != ORDER)
			results();
	endtask : wait_coef

	task automatic pack();
		@(negedge core_clk_i);
		head = HEAD_BITS'({rnd(), rnd(), rnd(), rnd(), rnd()});
		{lag3, gn3, gr3, pk3, lag4, gn4, gr4, pk4} = 34'({rnd(), rnd()});
		pc3 = 39'({rnd(), rnd()});
		pc4 = 39'({rnd(), rnd()});
		pbits = {pc4, pk4, gr4, gn4, lag4, pc3, pk3, gr3, gn3, lag3, head};
		nbit = 0;
		start = 1'b1;
		@(negedge core_clk_i);
		start = 1'b0;
		chk("pack_busy", 1, busy);
		repeat (20) @(negedge core_clk_i);
		// A start while busy must be ignored and new fields must not leak in.
		head = ~head;
		pc4 = ~pc4;
		start = 1'b1;
		@(negedge core_clk_i);
		start = 1'b0;
		for (int c = 0; c < 300 && (busy !== 1'b0 || nbit < FRAME_BITS); c++)
			@(negedge core_clk_i);
		repeat (3) @(negedge core_clk_i);
		chk("frame_bits_sent", FRAME_BITS, nbit);
		chk("pack_idle", 2'b00, {busy, fbv});
		if (nbit != FRAME_BITS)
			results();
	endtask : pack

	initial begin
		do_reset();
		put(FRAME_LEN);
		wait_coef();
		put(FRAME_LEN);
		wait_coef();
		@(negedge core_clk_i);
		for (int i = 0; i < 30; i++) begin
			lar_in = (i < 6) ? 16'(5529 + 4505 * (i % 3) + i / 3)
				: (i == 6) ? 16'h8000 : (i == 7) ? 16'h7fff : 16'(rnd());
			lar_v = 1'b1;
			invq.push_back(lar_in);
			@(negedge core_clk_i);
		end
		lar_v = 1'b0;
		@(negedge core_clk_i);
		chk("refl_inv_count", 0, invq.size());
		pack();
		pack();
		put(50);
		do_reset();
		put(FRAME_LEN);
		wait_coef();
		repeat (5) @(negedge core_clk_i);
		results();
	end
endmodule : selfe_front_end_bench

/* tb/selfe_pcm_source.sv */
// Model of the PCM sample source that feeds the front end.
`timescale 1ns/10ps
module selfe_pcm_source
	import selfe_pkg::*;
(
	input  wire logic                    core_clk_i,
	input  wire logic                    send_i,
	input  wire logic signed [SMP_W-1:0] value_i,
	output logic signed [SMP_W-1:0]      sample_o,
	output logic                         sample_valid_o
);
	initial begin
		sample_o = '0;
		sample_valid_o = 1'b0;
	end
	// Between words the line toggles, so a stale word never looks valid.
	always @(negedge core_clk_i) begin
		if (send_i) begin
			sample_o <= value_i;
			sample_valid_o <= 1'b1;
		end else begin
			sample_o <= ~sample_o;
			sample_valid_o <= 1'b0;
		end
	end
endmodule : selfe_pcm_source
